// >>> hdl/tbdc_pkg.sv
// package: register map, field layout, timing and types of the tuner bias dac control block
package tbdc_pkg;

  // register addresses on the serial link
  localparam logic [4:0] ADDR_PWR_MIRROR = 5'h00;
  localparam logic [4:0] ADDR_GLIDE_G1   = 5'h01;
  localparam logic [4:0] ADDR_DAC_A      = 5'h02;
  localparam logic [4:0] ADDR_DAC_C      = 5'h04;
  localparam logic [4:0] ADDR_GLIDE_G2   = 5'h05;
  localparam logic [4:0] ADDR_DAC_D      = 5'h06;
  localparam logic [4:0] ADDR_DAC_F      = 5'h08;
  localparam logic [4:0] ADDR_STATUS     = 5'h1A;
  localparam logic [4:0] ADDR_TRIG_CTRL  = 5'h1C;
  localparam logic [4:0] ADDR_SLAVE_ID   = 5'h1F;

  // command codes
  localparam logic [2:0] CMD_REG_WR = 3'h2;
  localparam logic [2:0] CMD_REG_RD = 3'h3;

  // field positions
  localparam int SWRST_BIT  = 7;
  localparam int TURBO_BIT  = 7;
  localparam int ACTIVE_BIT = 5;
  localparam int GLIDE_LSB  = 3;

  // power state encodings
  localparam logic [1:0] PWR_ACTIVE  = 2'h0;
  localparam logic [1:0] PWR_STARTUP = 2'h1;
  localparam logic [1:0] PWR_LOWPWR  = 2'h2;
  localparam logic [1:0] PWR_INVALID = 2'h3;

  // reset values
  localparam logic [3:0] USID_RST   = 4'h7;
  localparam logic [2:0] REG0_FIXED = 3'h2;

  // index of the last frame bit in link clock bits, counted from zero (parity included)
  localparam logic [3:0] CMD_LAST  = 4'hC;
  localparam logic [3:0] DATA_LAST = 4'h8;

  // glide step timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int GLIDE_UNIT_NS  = 2000;
  localparam int GLIDE_UNIT_CYC = (GLIDE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0]      pwr;
    logic            active;
    logic [2:0]      trig_mask;
    logic [2:0]      trig_en;
    logic [1:0][4:0] glide_dly;
    logic [5:0]      glide_en;
    logic [5:0]      turbo;
    logic [5:0][6:0] code;
  } tbdc_cfg_t;

  localparam tbdc_cfg_t CFG_RST = '0;

  typedef enum logic [2:0] {LK_CMD, LK_WDATA, LK_RPARK, LK_RDATA, LK_PARK} tbdc_link_st_t;

endpackage : tbdc_pkg

// >>> hdl/tbdc_regs.sv
// module: serial-link register bank and glide/turbo output control of the bias dac
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////////////////////////
// Function
// - power 00: active bit selects idle/operating
// - 01 restores defaults, 10 low power
// - power field shared by reg28 and reg0
// - reg28 holds trigger masks and enables
// - glide step delay is 2us times (n+1)
// - two glide registers, groups ABC and DEF
// - glide enable selects glide mode per output
// - turbo bit, ignored while gliding
// - seven-bit code sets each output level
// - status bit 7 write one: soft reset
// - soft reset keeps slave id, reg28
// - status bits report link errors
module tbdc_regs #(
  parameter int         GLIDE_UNIT_CYC = tbdc_pkg::GLIDE_UNIT_CYC,
  parameter logic [1:0] MAKER_CODE     = 2'h2  // arbitrary value
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            sclk_link,
  input  wire logic            sdata_i,
  output logic                 sdata_o,
  output logic                 sdata_oe,
  output logic [5:0][6:0]      dac_level,
  output logic [5:0]           boost_speed,
  output logic [5:0]           glide_mode,
  output logic [1:0]           power_state_field,
  output logic                 dac_operating,
  output logic [2:0]           trig_armed
);

  localparam int TMR_W = $clog2(32 * GLIDE_UNIT_CYC + 1);

  initial
  begin
    if (GLIDE_UNIT_CYC < 1)
      $error("GLIDE_UNIT_CYC must be at least one cycle");
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // link domain: frame decode on the falling edge of the link clock

  logic [1:0]              lrst_s_r;
  logic                    link_rst_n;
  tbdc_pkg::tbdc_link_st_t lk_st_r;
  tbdc_pkg::tbdc_cfg_t     lk_cfg_r;
  tbdc_pkg::tbdc_cfg_t     lk_cfg_nxt;
  logic [3:0]              usid_r;
  logic [3:0]              usid_nxt;
  logic [6:0]              stat_r;
  logic [6:0]              stat_nxt;
  logic [11:0]             sh_r;
  logic [3:0]              cnt_r;
  logic [4:0]              addr_r;
  logic                    hit_r;
  logic [8:0]              rsh_r;
  logic                    upd_tgl_r;
  logic [7:0]              rd_val;

  // reset into the link domain through two flops; the link clock must run to apply it
  always_ff @(negedge sclk_link)
  begin
    lrst_s_r <= {lrst_s_r[0], rst_n};
  end
  assign link_rst_n = lrst_s_r[1];

  wire [12:0] cmd_w      = {sh_r, sdata_i};
  wire [8:0]  dat_w      = {sh_r[7:0], sdata_i};
  wire        cmd_par_ok = ^cmd_w;
  wire        dat_par_ok = ^dat_w;
  wire        cmd_end    = (lk_st_r == tbdc_pkg::LK_CMD) && (cnt_r == tbdc_pkg::CMD_LAST);
  wire        dat_end    = (lk_st_r == tbdc_pkg::LK_WDATA) && (cnt_r == tbdc_pkg::DATA_LAST);
  wire        rd_end     = (lk_st_r == tbdc_pkg::LK_RDATA) && (cnt_r == tbdc_pkg::DATA_LAST);
  wire [2:0]  cmd_code   = cmd_w[8:6];
  wire        is_r0_wr   = cmd_w[8];
  wire        is_rd      = !is_r0_wr && (cmd_code == tbdc_pkg::CMD_REG_RD);
  wire        is_wr      = !is_r0_wr && (cmd_code == tbdc_pkg::CMD_REG_WR);
  // broadcast id 0 is accepted for writes only
  wire        own_id     = (cmd_w[12:9] == usid_r) || ((cmd_w[12:9] == 4'h0) && !is_rd);
  wire        r0_go      = cmd_end && is_r0_wr && cmd_par_ok && own_id;
  wire        wd_go      = dat_end && hit_r && dat_par_ok;
  wire        wr_go      = r0_go || wd_go;
  wire [4:0]  wr_addr    = r0_go ? tbdc_pkg::ADDR_PWR_MIRROR : addr_r;
  wire [7:0]  wr_data    = r0_go ? {1'b0, cmd_w[7:1]} : dat_w[8:1];

  // address decode for writes
  wire        dac_hit    = ((wr_addr >= tbdc_pkg::ADDR_DAC_A) && (wr_addr <= tbdc_pkg::ADDR_DAC_C))
                        || ((wr_addr >= tbdc_pkg::ADDR_DAC_D) && (wr_addr <= tbdc_pkg::ADDR_DAC_F));
  wire [2:0]  dac_idx    = (wr_addr <= tbdc_pkg::ADDR_DAC_C) ? 3'(wr_addr - tbdc_pkg::ADDR_DAC_A)
                                                           : 3'(wr_addr - 5'h03);
  wire        glide_hit  = (wr_addr == tbdc_pkg::ADDR_GLIDE_G1)
                        || (wr_addr == tbdc_pkg::ADDR_GLIDE_G2);
  wire        glide_grp  = (wr_addr == tbdc_pkg::ADDR_GLIDE_G2);
  wire        soft_rst   = wr_go && (wr_addr == tbdc_pkg::ADDR_STATUS) && wr_data[tbdc_pkg::SWRST_BIT];
  wire        known_addr = dac_hit || glide_hit || (wr_addr == tbdc_pkg::ADDR_PWR_MIRROR)
                        || (wr_addr == tbdc_pkg::ADDR_STATUS)
                        || (wr_addr == tbdc_pkg::ADDR_TRIG_CTRL)
                        || (wr_addr == tbdc_pkg::ADDR_SLAVE_ID);
  wire [6:0]  stat_set   = {4'h0, wd_go && !known_addr, dat_end && !dat_par_ok,
                            cmd_end && !cmd_par_ok};

  always_comb
  begin
    lk_cfg_nxt = lk_cfg_r;
    usid_nxt   = usid_r;
    if (wr_go)
    begin
      if (wr_addr == tbdc_pkg::ADDR_PWR_MIRROR)
      begin
        lk_cfg_nxt.active = wr_data[tbdc_pkg::ACTIVE_BIT];
        if (wr_data[1:0] != tbdc_pkg::PWR_INVALID)
          lk_cfg_nxt.pwr = wr_data[1:0];
      end
      if (wr_addr == tbdc_pkg::ADDR_TRIG_CTRL)
      begin
        lk_cfg_nxt.trig_mask = wr_data[5:3];
        lk_cfg_nxt.trig_en   = wr_data[2:0];
        if (wr_data[7:6] != tbdc_pkg::PWR_INVALID)
          lk_cfg_nxt.pwr = wr_data[7:6];
      end
      if (glide_hit)
      begin
        lk_cfg_nxt.glide_dly[glide_grp] = wr_data[7:tbdc_pkg::GLIDE_LSB];
        lk_cfg_nxt.glide_en[glide_grp * 3 + 0] = wr_data[2];
        lk_cfg_nxt.glide_en[glide_grp * 3 + 1] = wr_data[1];
        lk_cfg_nxt.glide_en[glide_grp * 3 + 2] = wr_data[0];
      end
      if (dac_hit)
      begin
        lk_cfg_nxt.turbo[dac_idx] = wr_data[tbdc_pkg::TURBO_BIT];
        lk_cfg_nxt.code[dac_idx]  = wr_data[6:0];
      end
      if (wr_addr == tbdc_pkg::ADDR_SLAVE_ID)
        usid_nxt = wr_data[3:0];
      if (soft_rst)
      begin
        lk_cfg_nxt           = tbdc_pkg::CFG_RST;
        lk_cfg_nxt.pwr       = lk_cfg_r.pwr;
        lk_cfg_nxt.trig_mask = lk_cfg_r.trig_mask;
        lk_cfg_nxt.trig_en   = lk_cfg_r.trig_en;
      end
    end
    // start-up returns to defaults and leaves the field at active
    if (lk_cfg_nxt.pwr == tbdc_pkg::PWR_STARTUP)
      lk_cfg_nxt = tbdc_pkg::CFG_RST;
    // a new error wins over the soft reset clearing the status bits
    stat_nxt = (soft_rst ? 7'h00 : stat_r) | stat_set;
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rd_val = 8'h00;
    if (addr_r == tbdc_pkg::ADDR_PWR_MIRROR)
      rd_val = {2'h0, lk_cfg_r.active, tbdc_pkg::REG0_FIXED, lk_cfg_r.pwr};
    else if ((addr_r == tbdc_pkg::ADDR_GLIDE_G1) || (addr_r == tbdc_pkg::ADDR_GLIDE_G2))
      rd_val = {lk_cfg_r.glide_dly[addr_r[2]], lk_cfg_r.glide_en[addr_r[2] * 3 + 0],
                lk_cfg_r.glide_en[addr_r[2] * 3 + 1], lk_cfg_r.glide_en[addr_r[2] * 3 + 2]};
    else if ((addr_r >= tbdc_pkg::ADDR_DAC_A) && (addr_r <= tbdc_pkg::ADDR_DAC_C))
      rd_val = {lk_cfg_r.turbo[3'(addr_r - tbdc_pkg::ADDR_DAC_A)],
                lk_cfg_r.code[3'(addr_r - tbdc_pkg::ADDR_DAC_A)]};
    else if ((addr_r >= tbdc_pkg::ADDR_DAC_D) && (addr_r <= tbdc_pkg::ADDR_DAC_F))
      rd_val = {lk_cfg_r.turbo[3'(addr_r - 5'h03)], lk_cfg_r.code[3'(addr_r - 5'h03)]};
    else if (addr_r == tbdc_pkg::ADDR_STATUS)
      rd_val = {1'b0, stat_r};
    else if (addr_r == tbdc_pkg::ADDR_TRIG_CTRL)
      rd_val = {lk_cfg_r.pwr, lk_cfg_r.trig_mask, lk_cfg_r.trig_en};
    else if (addr_r == tbdc_pkg::ADDR_SLAVE_ID)
      rd_val = {2'h0, MAKER_CODE, usid_r};
  end

  always_ff @(negedge sclk_link)
  begin
    if (!link_rst_n)
    begin
      lk_st_r   <= tbdc_pkg::LK_CMD;
      lk_cfg_r  <= tbdc_pkg::CFG_RST;
      usid_r    <= tbdc_pkg::USID_RST;
      stat_r    <= 7'h00;
      sh_r      <= 12'h000;
      cnt_r     <= 4'h0;
      addr_r    <= 5'h00;
      hit_r     <= 1'b0;
      rsh_r     <= 9'h000;
      upd_tgl_r <= 1'b0;
    end
    else
    begin
      lk_cfg_r <= lk_cfg_nxt;
      usid_r   <= usid_nxt;
      stat_r   <= stat_nxt;
      sh_r     <= cmd_w[11:0];
      cnt_r    <= 4'(cnt_r + 4'h1);
      rsh_r    <= {rsh_r[7:0], 1'b0};
      if (lk_cfg_nxt != lk_cfg_r)
        upd_tgl_r <= !upd_tgl_r;
      case (lk_st_r)
        tbdc_pkg::LK_CMD:
          if (cmd_end)
          begin
            cnt_r  <= 4'h0;
            addr_r <= cmd_w[5:1];
            hit_r  <= is_wr && own_id && cmd_par_ok;
            if (is_wr)
              lk_st_r <= tbdc_pkg::LK_WDATA;
            else if (is_rd)
              lk_st_r <= tbdc_pkg::LK_RPARK;
            else
              lk_st_r <= tbdc_pkg::LK_PARK;
            if (is_rd)
              hit_r <= own_id && cmd_par_ok;
          end
        tbdc_pkg::LK_WDATA:
          if (dat_end)
            lk_st_r <= tbdc_pkg::LK_PARK;
        tbdc_pkg::LK_RPARK:
        begin
          cnt_r   <= 4'h0;
          rsh_r   <= {rd_val, ~^rd_val};
          lk_st_r <= tbdc_pkg::LK_RDATA;
        end
        tbdc_pkg::LK_RDATA:
          if (rd_end)
            lk_st_r <= tbdc_pkg::LK_PARK;
        tbdc_pkg::LK_PARK:
        begin
          cnt_r   <= 4'h0;
          lk_st_r <= tbdc_pkg::LK_CMD;
        end
        default:
          lk_st_r <= tbdc_pkg::LK_CMD;
      endcase
    end
  end

  // read data launched on the rising edge, half a bit ahead of the master's sampling edge
  always_ff @(posedge sclk_link)
  begin
    if (!link_rst_n)
    begin
      sdata_o  <= 1'b0;
      sdata_oe <= 1'b0;
    end
    else
    begin
      sdata_o  <= rsh_r[8];
      sdata_oe <= (lk_st_r == tbdc_pkg::LK_RDATA) && hit_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // system domain: configuration copy and glide ramps

  logic [2:0]                 upd_s_r;
  tbdc_pkg::tbdc_cfg_t        sys_cfg_r;
  logic [1:0][TMR_W-1:0]      tmr_r;
  logic [1:0][TMR_W-1:0]      reload_w;
  logic [1:0]                 tick_w;
  logic [5:0][6:0]            lvl_nxt;

  // the link holds its copy steady for a whole frame, far longer than the three-flop handshake
  wire upd_w    = upd_s_r[2] ^ upd_s_r[1];
  wire op_w     = (sys_cfg_r.pwr == tbdc_pkg::PWR_ACTIVE) && sys_cfg_r.active;

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_grp
      assign reload_w[g] = TMR_W'((int'(sys_cfg_r.glide_dly[g]) + 1) * GLIDE_UNIT_CYC - 1);
      assign tick_w[g]   = (tmr_r[g] == '0);
    end
    for (genvar c = 0; c < 6; c++)
    begin : g_chan
      wire [6:0] tgt_w = op_w ? sys_cfg_r.code[c] : 7'h00;
      wire [6:0] stp_w = (dac_level[c] < tgt_w) ? 7'(dac_level[c] + 7'h01)
                       : (dac_level[c] > tgt_w) ? 7'(dac_level[c] - 7'h01) : dac_level[c];
      assign lvl_nxt[c] = !sys_cfg_r.glide_en[c] ? tgt_w
                        : (tick_w[c / 3] ? stp_w : dac_level[c]);
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    upd_s_r <= {upd_s_r[1:0], upd_tgl_r};
    if (!rst_n)
    begin
      upd_s_r           <= 3'h0;
      sys_cfg_r         <= tbdc_pkg::CFG_RST;
      tmr_r             <= '0;
      dac_level         <= '0;
      boost_speed       <= 6'h00;
      glide_mode        <= 6'h00;
      power_state_field <= tbdc_pkg::PWR_ACTIVE;
      dac_operating     <= 1'b0;
      trig_armed        <= 3'h0;
    end
    else
    begin
      if (upd_w)
        sys_cfg_r <= lk_cfg_r;
      for (int g = 0; g < 2; g++)
        tmr_r[g] <= tick_w[g] ? reload_w[g] : TMR_W'(tmr_r[g] - 1'b1);
      dac_level         <= lvl_nxt;
      boost_speed       <= sys_cfg_r.turbo & ~sys_cfg_r.glide_en & {6{op_w}};
      glide_mode        <= sys_cfg_r.glide_en;
      power_state_field <= sys_cfg_r.pwr;
      dac_operating     <= op_w;
      trig_armed        <= sys_cfg_r.trig_en & ~sys_cfg_r.trig_mask;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // checks

  logic [TMR_W-1:0] gap_r;
  logic             gap_ok_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || upd_w)
    begin
      gap_r    <= '0;
      gap_ok_r <= 1'b0;
    end
    else
    begin
      gap_r    <= tick_w[0] ? '0 : TMR_W'(gap_r + 1'b1);
      gap_ok_r <= gap_ok_r || tick_w[0];
    end
  end

  a_idle_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sys_cfg_r.pwr == tbdc_pkg::PWR_ACTIVE && !sys_cfg_r.active && !sys_cfg_r.glide_en[0])
    |=> (dac_level[0] == 7'h00))
    else $error("idle output did not go to zero");

  a_startup_dflt: assert property (@(negedge sclk_link) disable iff (!link_rst_n)
    (wr_go && wr_addr == tbdc_pkg::ADDR_TRIG_CTRL && wr_data[7:6] == tbdc_pkg::PWR_STARTUP)
    |=> (lk_cfg_r == tbdc_pkg::CFG_RST))
    else $error("start-up did not restore defaults");

  a_pwr_mirror: assert property (@(negedge sclk_link) disable iff (!link_rst_n)
    (r0_go && cmd_w[2:1] == tbdc_pkg::PWR_LOWPWR)
    |=> (lk_cfg_r.pwr == tbdc_pkg::PWR_LOWPWR))
    else $error("power field not shared with reg0");

  a_trig_store: assert property (@(negedge sclk_link) disable iff (!link_rst_n)
    (wd_go && addr_r == tbdc_pkg::ADDR_TRIG_CTRL && dat_w[8:7] == tbdc_pkg::PWR_ACTIVE)
    |=> ({lk_cfg_r.trig_mask, lk_cfg_r.trig_en} == $past(dat_w[6:1])))
    else $error("trigger control not stored");

  a_glide_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tick_w[0] && gap_ok_r) |-> (gap_r == reload_w[0]))
    else $error("glide step spacing wrong");

  a_glide_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(sys_cfg_r.glide_en[0]) && dac_level[0] != $past(dac_level[0]))
    |-> $past(tick_w[0]))
    else $error("gliding output moved without a step tick");

  a_turbo_glide: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (boost_speed & glide_mode) == 6'h00)
    else $error("turbo active on a gliding output");

  a_level_jump: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (op_w && !sys_cfg_r.glide_en[1]) |=> (dac_level[1] == $past(sys_cfg_r.code[1])))
    else $error("output level does not follow code");

  a_soft_keep: assert property (@(negedge sclk_link) disable iff (!link_rst_n)
    soft_rst |=> (lk_cfg_r.code == '0) && $stable(usid_r) && $stable(lk_cfg_r.trig_en)
                 && $stable(lk_cfg_r.trig_mask))
    else $error("soft reset scope wrong");

  a_parity_flag: assert property (@(negedge sclk_link) disable iff (!link_rst_n)
    (cmd_end && !cmd_par_ok) |=> stat_r[0])
    else $error("command parity error not reported");

  a_usid_prog: assert property (@(negedge sclk_link) disable iff (!link_rst_n)
    (wd_go && addr_r == tbdc_pkg::ADDR_SLAVE_ID) |=> (usid_r == $past(dat_w[4:1])))
    else $error("slave id not reprogrammed");

  c_glide_ramp: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sys_cfg_r.glide_en[0] && tick_w[0] ##1 $changed(dac_level[0]));
  c_soft_reset: cover property (@(negedge sclk_link) disable iff (!link_rst_n) soft_rst);
  c_read_drive: cover property (@(posedge sclk_link) disable iff (!link_rst_n) sdata_oe);

endmodule : tbdc_regs

// >>> verification/tbdc_master.sv
// serial link master model: makes the link clock, drives frames, samples read data
`timescale 1ns/1ns
module tbdc_master (
  output logic      sclk_link,
  output logic      sdata_m,
  input  wire logic sdata_line
);
  logic [7:0] rd_val;
  logic       rd_par;
  int         rd_cnt;

  initial
  begin
    sclk_link = 1'b0;
    sdata_m   = 1'b0;
    rd_cnt    = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock rests low between frames; data moves on the rising edge, held over the fall
  task automatic bit_out(input logic b);
    sclk_link = 1'b1;
    sdata_m   = b;
    #7;
    sclk_link = 1'b0;
    #8;
  endtask : bit_out

  task automatic idle(input int n);
    repeat (n) bit_out(1'b0);
  endtask : idle

  // hdr is {1,d[6:0]} for a reg0 write or {cmd,addr}; bad spoils the command parity
  task automatic frame(input logic [3:0] sa, input logic [7:0] hdr, input logic [7:0] d,
                       input logic bad);
    logic [11:0] c;
    c = {sa, hdr};
    for (int i = 11; i >= 0; i--) bit_out(c[i]);
    bit_out(~^c ^ bad);
    if (hdr[7:5] == tbdc_pkg::CMD_REG_WR)
    begin
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_out(~^d);
    end
    bit_out(1'b0);
  endtask : frame

  task automatic rd(input logic [3:0] sa, input logic [4:0] a);
    logic [11:0] c;
    logic [8:0]  v;
    c = {sa, tbdc_pkg::CMD_REG_RD, a};
    for (int i = 11; i >= 0; i--) bit_out(c[i]);
    bit_out(~^c);
    bit_out(1'b0);
    // released line: shows the inverse of the park level, never a friendly copy
    sdata_m = 1'b1;
    for (int i = 8; i >= 0; i--)
    begin
      sclk_link = 1'b1;
      #7;
      sclk_link = 1'b0;
      v[i] = sdata_line;
      #8;
    end
    bit_out(1'b0);
    rd_val = v[8:1];
    rd_par = ^v;
    rd_cnt++;
  endtask : rd
endmodule : tbdc_master

// >>> verification/test_tuner_bias_dac_control_regs.sv
// self-checking bench for the tuner bias dac register bank
`timescale 1ns/1ns
module test_tuner_bias_dac_control_regs;
  localparam int         UNIT  = 4;
  localparam logic [1:0] MAKER = 2'h2;  // arbitrary value
  localparam logic [4:0] DA [6] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h08};
  logic            clk_sys;
  logic            rst_n;
  wire logic       sclk_link;
  wire logic       sdata_m;
  wire logic       sdata_line;
  logic            sdata_o;
  logic            sdata_oe;
  logic [5:0][6:0] dac_level;
  logic [5:0]      boost_speed;
  logic [5:0]      glide_mode;
  logic [1:0]      power_state_field;
  logic            dac_operating;
  logic [2:0]      trig_armed;
  int              err_count;
  int              cmp_count;
  int              cyc;
  logic [3:0]      sid;
  logic [7:0]      exp_q[$];

  assign sdata_line = sdata_oe ? sdata_o : sdata_m;

  tbdc_regs #(
    .GLIDE_UNIT_CYC (UNIT),
    .MAKER_CODE     (MAKER)
  ) uut (
    .clk_sys           (clk_sys),
    .rst_n             (rst_n),
    .sclk_link         (sclk_link),
    .sdata_i           (sdata_line),
    .sdata_o           (sdata_o),
    .sdata_oe          (sdata_oe),
    .dac_level         (dac_level),
    .boost_speed       (boost_speed),
    .glide_mode        (glide_mode),
    .power_state_field (power_state_field),
    .dac_operating     (dac_operating),
    .trig_armed        (trig_armed)
  );

  tbdc_master mst (
    .sclk_link  (sclk_link),
    .sdata_m    (sdata_m),
    .sdata_line (sdata_line)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    mst.frame(sid, {tbdc_pkg::CMD_REG_WR, a}, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    mst.rd(sid, a);
  endtask : rd

  // outputs cross into clk_sys a few cycles after the write lands
  task automatic settle();
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic wait_step(output int n);
    logic [6:0] lv;
    lv = dac_level[0];
    n = 0;
    while (dac_level[0] === lv && n < 40)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wait_step

  ////////////////////////////////////////////////////////////////////////////////
  // results come back in request order, so the oldest note always matches
  initial
  forever
  begin
    @(mst.rd_cnt);
    check("rd_parity", {7'h0, mst.rd_par}, 8'h01);
    check("rd_data", mst.rd_val, exp_q.pop_front());
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end

  initial
  begin
    logic [7:0] v;
    logic [6:0] lv;
    int         n;
    err_count = 0;
    cmp_count = 0;
    cyc = 0;
    sid = 4'h7;
    rst_n = 1'b0;
    void'($urandom(32'hdc0e));
    // link clock must run while reset is held
    fork
      repeat (4) @(posedge clk_sys);
      mst.idle(6);
    join
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    // the link reset leaves on the second fall, so a third idle bit would count as a frame bit
    mst.idle(2);
    rd(tbdc_pkg::ADDR_SLAVE_ID, {2'b00, MAKER, 4'h7});
    rd(tbdc_pkg::ADDR_PWR_MIRROR, 8'h08);
    rd(tbdc_pkg::ADDR_STATUS, 8'h00);
    mst.frame(sid, 8'hA8, 8'h00, 1'b0);
    settle();
    check("operating", {7'h0, dac_operating}, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      v = 8'($urandom());
      wr(DA[i], v);
      settle();
      check("dac_level", {1'b0, dac_level[i]}, {1'b0, v[6:0]});
      check("boost", {7'h0, boost_speed[i]}, {7'h0, v[7]});
      rd(DA[i], v);
    end
    wr(tbdc_pkg::ADDR_DAC_A, 8'h05);
    wr(tbdc_pkg::ADDR_GLIDE_G1, 8'h0C);
    wr(tbdc_pkg::ADDR_DAC_A, 8'h9D);
    settle();
    check("glide_mode", {2'b00, glide_mode}, 8'h01);
    check("boost", {7'h0, boost_speed[0]}, 8'h00);
    wait_step(n);
    lv = dac_level[0];
    wait_step(n);
    check("glide_step", 8'(n), 8'(2 * UNIT));
    check("glide_dir", {1'b0, dac_level[0]}, {1'b0, lv + 7'h01});
    repeat (250) @(posedge clk_sys);
    #1;
    check("glide_end", {1'b0, dac_level[0]}, 8'h1D);
    wr(tbdc_pkg::ADDR_GLIDE_G2, 8'h04);
    settle();
    check("glide_mode", {2'b00, glide_mode}, 8'h09);
    wr(tbdc_pkg::ADDR_TRIG_CTRL, 8'h2F);
    settle();
    check("trig_armed", {5'h0, trig_armed}, 8'h02);
    rd(tbdc_pkg::ADDR_PWR_MIRROR, 8'h28);
    wr(tbdc_pkg::ADDR_TRIG_CTRL, 8'hAF);
    settle();
    check("power", {6'h0, power_state_field}, 8'h02);
    check("operating", {7'h0, dac_operating}, 8'h00);
    rd(tbdc_pkg::ADDR_PWR_MIRROR, 8'h2A);
    wr(tbdc_pkg::ADDR_TRIG_CTRL, 8'hEF);
    settle();
    check("power", {6'h0, power_state_field}, 8'h02);
    wr(tbdc_pkg::ADDR_TRIG_CTRL, 8'h40);
    settle();
    check("power", {6'h0, power_state_field}, 8'h00);
    rd(tbdc_pkg::ADDR_DAC_A, 8'h00);
    rd(tbdc_pkg::ADDR_GLIDE_G2, 8'h00);
    rd(tbdc_pkg::ADDR_TRIG_CTRL, 8'h00);
    mst.frame(sid, {tbdc_pkg::CMD_REG_WR, tbdc_pkg::ADDR_DAC_C}, 8'h11, 1'b1);
    rd(tbdc_pkg::ADDR_DAC_C, 8'h00);
    rd(tbdc_pkg::ADDR_STATUS, 8'h01);
    wr(5'h0C, 8'h5A);
    rd(tbdc_pkg::ADDR_STATUS, 8'h05);
    rd(5'h0C, 8'h00);
    wr(tbdc_pkg::ADDR_TRIG_CTRL, 8'h07);
    wr(5'h03, 8'h33);
    wr(tbdc_pkg::ADDR_SLAVE_ID, 8'h05);
    sid = 4'h5;
    rd(tbdc_pkg::ADDR_SLAVE_ID, {2'b00, MAKER, 4'h5});
    wr(tbdc_pkg::ADDR_STATUS, 8'h80);
    rd(5'h03, 8'h00);
    rd(tbdc_pkg::ADDR_STATUS, 8'h00);
    rd(tbdc_pkg::ADDR_TRIG_CTRL, 8'h07);
    rd(tbdc_pkg::ADDR_SLAVE_ID, {2'b00, MAKER, 4'h5});
    repeat (2) @(posedge clk_sys);
    give_verdict();
  end
endmodule : test_tuner_bias_dac_control_regs
